// *** src/cycle_timer.sv ***
// Down counter that stays busy for a loaded number of clock cycles.
`timescale 1ns/1ps
module cycle_timer
	import flash_seq_pkg::*;
(
	input  wire logic             core_clk,
	input  wire logic             rst,
	input  wire logic             start,
	input  wire logic [TMR_W-1:0] load,
	output logic                  busy
);
	logic [TMR_W-1:0] count;

	always_ff @(posedge core_clk)
	begin
		if (rst)
			count <= '0;
		else if (start)
			count <= load - TMR_W'(1);
		else if (count != '0)
			count <= count - TMR_W'(1);
	end

	assign busy = start || (count != '0);
endmodule : cycle_timer

// *** src/flash_seq_pkg.sv ***
// Package with the constants and types of the program flash self-write sequencer.
package flash_seq_pkg;
	localparam int ADDR_W = 10;
	localparam int DATA_W = 14;
	localparam int TMR_W = 23;
	localparam int CLK_MHZ = 125;
	localparam int POWER_UP_TIME_MS = 64;
	localparam int ERASE_TIME_MS = 4;
	localparam int POWER_UP_CYCLES = POWER_UP_TIME_MS * CLK_MHZ * 1000;
	localparam int ERASE_CYCLES = ERASE_TIME_MS * CLK_MHZ * 1000;
	localparam logic [1:0] SETUP_CYCLES = 2'h2;
	localparam int GROUP_WORDS = 4;
	localparam int ERASE_WORDS = 16;
	localparam int SEG_COUNT = 4;
	localparam int SEG_MSB = ADDR_W - 1;
	localparam int SEG_LSB = ADDR_W - 2;
	localparam logic [1:0] LAST_IN_GROUP = 2'h3;
	localparam logic [7:0] KEY_FIRST = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'haa;
	localparam logic [2:0] SEL_ADDR_LOW = 3'h0;
	localparam logic [2:0] SEL_ADDR_HIGH = 3'h1;
	localparam logic [2:0] SEL_DATA_LOW = 3'h2;
	localparam logic [2:0] SEL_DATA_HIGH = 3'h3;
	localparam logic [2:0] SEL_CONTROL = 3'h4;
	localparam logic [2:0] SEL_UNLOCK_KEY = 3'h5;
	localparam int CTRL_RD = 0;
	localparam int CTRL_WR = 1;
	localparam int CTRL_PERMIT = 2;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	typedef enum logic [1:0] {KEY_NONE, KEY_GOT_FIRST, KEY_ARMED} key_state_t;
	typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_LOAD, ST_ERASE, ST_PROG, ST_READ} seq_state_t;
endpackage : flash_seq_pkg

// *** src/program_flash_self_write.sv ***
// Program flash self-write sequencer with unlock key, group buffer and protection.
// Summary of operation
// - Self-writes into protected segments never change the program memory.
// - Words are grouped in aligned fours, starting where the low two address bits are zero.
// - A commit erases sixteen words, then writes four, never across a group boundary.
// - Key 55h then AAh, then the write-start bit, latches the word into the buffer.
// - Buffering the word with low bits 11 erases and programs the whole group.
// - Two setup cycles follow the write-start; software places two no-operations.
// - Buffering the first three words of a group never stalls the processor.
// - Only the erase and following write stall the processor; clocks keep running.
// - Execution resumes at the third instruction after the write-start.
// - Reset clears the write-permit bit.
// - No program memory write happens while the 64 ms power-up timer runs.
// - Code protection keeps processor access plain but refuses test mode access.
// - Write protection blocks serial port writes into protected segments, not processor self-writes.
`timescale 1ns/1ps
module program_flash_self_write
	import flash_seq_pkg::*;
#(
	parameter logic [TMR_W-1:0] POWER_UP_TIMER_CYCLES  = TMR_W'(POWER_UP_CYCLES),
	parameter logic [TMR_W-1:0] ERASE_CYCLES_P = TMR_W'(ERASE_CYCLES)
)
(
	input  wire logic                 core_clk,
	input  wire logic                 rst,
	input  wire logic                 reg_wr_en,
	input  wire logic [2:0]           reg_sel,
	input  wire logic [7:0]           reg_wr_data,
	output logic [7:0]                reg_rd_data,
	output logic                      cpu_stall,
	input  wire logic [SEG_COUNT-1:0] segment_protect,
	input  wire logic                 code_protect,
	input  wire logic                 write_protect,
	input  wire logic                 test_mode_req,
	output logic                      test_mode_grant,
	input  wire logic                 serial_wr_req,
	input  wire logic [ADDR_W-1:0]    serial_wr_addr,
	input  wire logic [DATA_W-1:0]    serial_wr_data,
	output logic                      serial_wr_refused,
	output logic [ADDR_W-1:0]         flash_addr,
	output logic                      flash_rd,
	input  wire logic [DATA_W-1:0]    flash_rd_data,
	output logic                      flash_erase,
	output logic                      flash_wr,
	output logic [DATA_W-1:0]         flash_wr_data,
	output logic                      power_up_busy
);
	logic [7:0]        prog_addr_low;
	logic [7:0]        prog_addr_high;
	logic [7:0]        prog_data_low;
	logic [5:0]        prog_data_high;
	logic [7:0]        prog_mem_control;
	key_state_t        key_state;
	seq_state_t        state;
	logic [1:0]        setup_cnt;
	logic [2:0]        prog_step;
	logic              power_up_timer_started;
	logic              power_up_timer_busy;
	logic              erase_start;
	logic              erase_busy;
	logic              write_block;
	logic              start_ok;
	logic              read_ok;
	logic              commit_ok;
	logic              serial_ok;
	logic [ADDR_W-1:0] prog_addr;
	logic [DATA_W-1:0] prog_word;
	logic [ADDR_W-1:0] group_base;
	logic              idle_wr;

	word_buffer_if buf_bus ();

	word_buffer u_buffer (
		.core_clk (core_clk),
		.rst      (rst),
		.bus      (buf_bus)
	);

	cycle_timer u_power_up_timer (
		.core_clk (core_clk),
		.rst      (rst),
		.start    (!power_up_timer_started),
		.load     (POWER_UP_TIMER_CYCLES),
		.busy     (power_up_timer_busy)
	);

	cycle_timer u_erase (
		.core_clk (core_clk),
		.rst      (rst),
		.start    (erase_start),
		.load     (ERASE_CYCLES_P),
		.busy     (erase_busy)
	);

	assign prog_addr = {prog_addr_high[1:0], prog_addr_low};
	assign prog_word = {prog_data_high, prog_data_low};
	assign group_base = {prog_addr[ADDR_W-1:2], 2'h0};
	assign idle_wr = reg_wr_en && state == ST_IDLE;
	assign write_block = power_up_timer_busy || !power_up_timer_started;
	assign power_up_busy = write_block;

	// Write-start counts only with permit, a fresh key and no power-up hold.
	assign start_ok = idle_wr && reg_sel == SEL_CONTROL && reg_wr_data[CTRL_WR]
		&& key_state == KEY_ARMED && prog_mem_control[CTRL_PERMIT] && !write_block;
	assign read_ok = idle_wr && reg_sel == SEL_CONTROL && reg_wr_data[CTRL_RD] && !start_ok;
	assign commit_ok = !segment_protect[prog_addr[SEG_MSB:SEG_LSB]] && !write_block;
	assign serial_ok = serial_wr_req && state == ST_IDLE && !write_block && !read_ok
		&& !(write_protect && segment_protect[serial_wr_addr[SEG_MSB:SEG_LSB]]);
	assign test_mode_grant = test_mode_req && !code_protect;
	assign erase_start = state == ST_SETUP && setup_cnt == SETUP_CYCLES - 2'h1
		&& prog_addr[1:0] == LAST_IN_GROUP && commit_ok;
	assign cpu_stall = state == ST_ERASE || state == ST_PROG;

	always_ff @(posedge core_clk)
	begin
		if (rst)
			power_up_timer_started <= 1'b0;
		else
			power_up_timer_started <= 1'b1;
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
			key_state <= KEY_NONE;
		else if (idle_wr && reg_sel == SEL_UNLOCK_KEY && reg_wr_data == KEY_FIRST)
			key_state <= KEY_GOT_FIRST;
		else if (idle_wr && reg_sel == SEL_UNLOCK_KEY && reg_wr_data == KEY_SECOND
			&& key_state == KEY_GOT_FIRST)
			key_state <= KEY_ARMED;
		else if (idle_wr)
			key_state <= KEY_NONE;
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			prog_addr_low <= '0;
			prog_addr_high <= '0;
		end
		else if (idle_wr && reg_sel == SEL_ADDR_LOW)
			prog_addr_low <= reg_wr_data;
		else if (idle_wr && reg_sel == SEL_ADDR_HIGH)
			prog_addr_high <= reg_wr_data;
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			prog_data_low <= '0;
			prog_data_high <= '0;
		end
		else if (state == ST_READ)
			{prog_data_high, prog_data_low} <= flash_rd_data;
		else if (idle_wr && reg_sel == SEL_DATA_LOW)
			prog_data_low <= reg_wr_data;
		else if (idle_wr && reg_sel == SEL_DATA_HIGH)
			prog_data_high <= reg_wr_data[5:0];
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
			prog_mem_control <= CONTROL_RESET;
		else if (idle_wr && reg_sel == SEL_CONTROL)
		begin
			prog_mem_control[CTRL_PERMIT] <= reg_wr_data[CTRL_PERMIT];
			prog_mem_control[CTRL_WR] <= start_ok;
			prog_mem_control[CTRL_RD] <= read_ok;
		end
		else if (state == ST_READ)
			prog_mem_control[CTRL_RD] <= 1'b0;
		else if (state == ST_LOAD || (state == ST_PROG && prog_step == 3'(GROUP_WORDS)))
			prog_mem_control[CTRL_WR] <= 1'b0;
		else if (state == ST_SETUP && setup_cnt == SETUP_CYCLES - 2'h1
			&& prog_addr[1:0] == LAST_IN_GROUP && !commit_ok)
			prog_mem_control[CTRL_WR] <= 1'b0;
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
			state <= ST_IDLE;
		else
		begin
			case (state)
				ST_IDLE:
				begin
					if (start_ok)
						state <= ST_SETUP;
					else if (read_ok)
						state <= ST_READ;
				end
				ST_SETUP:
				begin
					if (setup_cnt == SETUP_CYCLES - 2'h1)
					begin
						if (prog_addr[1:0] != LAST_IN_GROUP)
							state <= ST_LOAD;
						else if (commit_ok)
							state <= ST_ERASE;
						else
							state <= ST_IDLE;
					end
				end
				ST_LOAD: state <= ST_IDLE;
				ST_ERASE:
				begin
					if (!erase_busy)
						state <= ST_PROG;
				end
				ST_PROG:
				begin
					if (prog_step == 3'(GROUP_WORDS))
						state <= ST_IDLE;
				end
				ST_READ: state <= ST_IDLE;
				default: state <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst || state != ST_SETUP)
			setup_cnt <= '0;
		else
			setup_cnt <= setup_cnt + 2'h1;
	end

	always_ff @(posedge core_clk)
	begin
		if (rst || state != ST_PROG)
			prog_step <= '0;
		else
			prog_step <= prog_step + 3'h1;
	end

	// The word at the last group slot goes to the buffer in the same cycle as the commit.
	assign buf_bus.wr_en = (state == ST_LOAD) || erase_start;
	assign buf_bus.wr_idx = prog_addr[1:0];
	assign buf_bus.wr_data = prog_word;
	assign buf_bus.rd_idx = prog_step[1:0];

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			flash_erase <= 1'b0;
			flash_wr <= 1'b0;
			flash_rd <= 1'b0;
			flash_addr <= '0;
			flash_wr_data <= '0;
			serial_wr_refused <= 1'b0;
		end
		else
		begin
			flash_erase <= erase_start;
			flash_rd <= read_ok;
			flash_wr <= 1'b0;
			serial_wr_refused <= serial_wr_req && !serial_ok;
			if (erase_start)
				flash_addr <= {prog_addr[ADDR_W-1:4], 4'h0};
			else if (read_ok)
				flash_addr <= prog_addr;
			else if (state == ST_PROG && prog_step != '0)
			begin
				flash_wr <= 1'b1;
				flash_addr <= group_base | ADDR_W'(prog_step - 3'h1);
				flash_wr_data <= buf_bus.rd_data;
			end
			else if (serial_ok)
			begin
				flash_wr <= 1'b1;
				flash_addr <= serial_wr_addr;
				flash_wr_data <= serial_wr_data;
			end
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
			reg_rd_data <= '0;
		else
		begin
			case (reg_sel)
				SEL_ADDR_LOW: reg_rd_data <= prog_addr_low;
				SEL_ADDR_HIGH: reg_rd_data <= prog_addr_high;
				SEL_DATA_LOW: reg_rd_data <= prog_data_low;
				SEL_DATA_HIGH: reg_rd_data <= {2'h0, prog_data_high};
				SEL_CONTROL: reg_rd_data <= prog_mem_control;
				default: reg_rd_data <= '0;
			endcase
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	chk_erase_stall: assert property (flash_erase |-> cpu_stall)
		else $error("Erase issued without stalling the processor.");
	chk_load_nostall: assert property (state == ST_LOAD |-> !cpu_stall)
		else $error("Buffer load stalled the processor.");
	chk_setup_two: assert property (start_ok |=> state == ST_SETUP ##1 state == ST_SETUP)
		else $error("Setup did not last two cycles.");
	chk_permit_reset: assert property
		($rose(power_up_timer_started) |-> !prog_mem_control[CTRL_PERMIT])
		else $error("Write permit not clear after reset.");
	chk_power_up_timer_block: assert property (write_block |=> !flash_wr && !flash_erase)
		else $error("Program memory written during power-up hold.");
	chk_protect_seg: assert property
		(erase_start |-> !segment_protect[prog_addr[SEG_MSB:SEG_LSB]])
		else $error("Erase started in a protected segment.");
	chk_key_needed: assert property
		(state == ST_IDLE ##1 state == ST_SETUP |-> $past(key_state == KEY_ARMED))
		else $error("Write started without the unlock key.");
	chk_four_writes: assert property
		($fell(erase_busy) && state == ST_ERASE |=> ##2 flash_wr [*4])
		else $error("Commit did not program four words.");
	chk_wr_clear: assert property (state == ST_LOAD |=> !prog_mem_control[CTRL_WR])
		else $error("Write-start bit not cleared after load.");
	chk_serial_wp: assert property (serial_wr_req && write_protect
		&& segment_protect[serial_wr_addr[SEG_MSB:SEG_LSB]] |=> serial_wr_refused)
		else $error("Serial port wrote a protected region.");
	chk_test_refuse: assert property (code_protect |-> !test_mode_grant)
		else $error("Test mode access granted under code protection.");

	cov_buffer_load: cover property (state == ST_LOAD);
	cov_commit: cover property (flash_erase ##[1:1000] flash_wr);
	cov_read: cover property (flash_rd ##1 state == ST_IDLE);
endmodule : program_flash_self_write

// *** src/word_buffer.sv ***
// Four-word holding buffer with registered read data.
`timescale 1ns/1ps
module word_buffer
	import flash_seq_pkg::*;
(
	input  wire logic   core_clk,
	input  wire logic   rst,
	word_buffer_if.store bus
);
	logic [DATA_W-1:0] words [GROUP_WORDS];

	genvar i;
	generate
		for (i = 0; i < GROUP_WORDS; i++)
		begin : g_word
			always_ff @(posedge core_clk)
			begin
				if (rst)
					words[i] <= '0;
				else if (bus.wr_en && bus.wr_idx == 2'(i))
					words[i] <= bus.wr_data;
			end
		end
	endgenerate

	always_ff @(posedge core_clk)
	begin
		if (rst)
			bus.rd_data <= '0;
		else
			bus.rd_data <= words[bus.rd_idx];
	end
endmodule : word_buffer

// *** src/word_buffer_if.sv ***
// Interface that carries the four-word holding buffer ports.
`timescale 1ns/1ps
interface word_buffer_if;
	import flash_seq_pkg::*;
	logic              wr_en;
	logic [1:0]        wr_idx;
	logic [DATA_W-1:0] wr_data;
	logic [1:0]        rd_idx;
	logic [DATA_W-1:0] rd_data;
	modport owner (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
	modport store (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface : word_buffer_if

// *** tb/tb.sv ***
// Self-checking bench for the program flash self-write sequencer.
`timescale 1ns/1ps
module tb;
	import flash_seq_pkg::*;
	typedef struct {logic [2:0] sel; logic [7:0] wd; logic [7:0] exp;} row_t;
	localparam int ERASE_SIM = 10;
	logic                 core_clk = 1'b0, rst = 1'b1, reg_wr_en = 1'b0, serial_wr_req = 1'b0;
	logic                 code_protect = 1'b0, write_protect = 1'b0, test_mode_req = 1'b0;
	logic [2:0]           reg_sel = 3'h0;
	logic [7:0]           reg_wr_data = 8'h00, reg_rd_data, v;
	logic [SEG_COUNT-1:0] segment_protect = 4'h0;
	logic [ADDR_W-1:0]    serial_wr_addr = 10'h000, flash_addr, erase_addr, rd_addr;
	logic [DATA_W-1:0]    serial_wr_data = 14'h0000, flash_wr_data, e;
	logic                 cpu_stall, test_mode_grant, serial_wr_refused, power_up_busy;
	logic                 flash_rd, flash_erase, flash_wr;
	wire  [DATA_W-1:0]    flash_rd_data = {4'h2, flash_addr};
	int                   failures = 0, tests_run = 0, erase_n = 0, stall_n = 0, refused_n = 0;
	logic [ADDR_W-1:0]    wq_a[$];
	logic [DATA_W-1:0]    wq_d[$];
	row_t                 rows[8] = '{'{3'h0, 8'ha5, 8'ha5}, '{3'h1, 8'h02, 8'h02},
		'{3'h2, 8'h3c, 8'h3c}, '{3'h3, 8'h15, 8'h15}, '{3'h5, 8'h55, 8'h00},
		'{3'h6, 8'h77, 8'h00}, '{3'h7, 8'h11, 8'h00}, '{3'h4, 8'h04, 8'h04}};

	program_flash_self_write #(.POWER_UP_TIMER_CYCLES(23'h28), .ERASE_CYCLES_P(23'(ERASE_SIM)))
		u_program_flash_self_write (
		.core_clk(core_clk), .rst(rst), .reg_wr_en(reg_wr_en), .reg_sel(reg_sel),
		.reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data), .cpu_stall(cpu_stall),
		.segment_protect(segment_protect), .code_protect(code_protect),
		.write_protect(write_protect), .test_mode_req(test_mode_req),
		.test_mode_grant(test_mode_grant), .serial_wr_req(serial_wr_req),
		.serial_wr_addr(serial_wr_addr), .serial_wr_data(serial_wr_data),
		.serial_wr_refused(serial_wr_refused), .flash_addr(flash_addr), .flash_rd(flash_rd),
		.flash_rd_data(flash_rd_data), .flash_erase(flash_erase), .flash_wr(flash_wr),
		.flash_wr_data(flash_wr_data), .power_up_busy(power_up_busy));

	initial
	begin
		forever #4 core_clk = ~core_clk;
	end

	// Records every flash strobe so scenarios can count what reached the array.
	always @(posedge core_clk)
	begin
		if (flash_wr === 1'b1)
		begin
			wq_a.push_back(flash_addr);
			wq_d.push_back(flash_wr_data);
		end
		if (flash_erase === 1'b1)
		begin
			erase_n++;
			erase_addr = flash_addr;
		end
		if (flash_rd === 1'b1) rd_addr = flash_addr;
		if (cpu_stall === 1'b1) stall_n++;
		if (serial_wr_refused === 1'b1) refused_n++;
	end

	task automatic clear_log;
		erase_n = 0;
		stall_n = 0;
		refused_n = 0;
		wq_a.delete();
		wq_d.delete();
	endtask : clear_log

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [2:0] sel, input logic [7:0] d);
		@(posedge core_clk);
		reg_wr_en <= 1'b1;
		reg_sel <= sel;
		reg_wr_data <= d;
		@(posedge core_clk);
		reg_wr_en <= 1'b0;
	endtask : wr

	task automatic rd(input logic [2:0] sel);
		@(posedge core_clk);
		reg_sel <= sel;
		@(posedge core_clk);
		#1;
		v = reg_rd_data;
	endtask : rd

	// Waits out setup, load or commit with a bounded count.
	task automatic settle;
		int n;
		repeat (4) @(posedge core_clk);
		n = 0;
		while (cpu_stall !== 1'b0 && n < 200)
		begin
			@(posedge core_clk);
			n++;
		end
		@(posedge core_clk);
		#1;
	endtask : settle

	task automatic put_word(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		wr(SEL_ADDR_LOW, a[7:0]);
		wr(SEL_ADDR_HIGH, {6'h00, a[9:8]});
		wr(SEL_DATA_LOW, d[7:0]);
		wr(SEL_DATA_HIGH, {2'h0, d[13:8]});
		wr(SEL_UNLOCK_KEY, KEY_FIRST);
		wr(SEL_UNLOCK_KEY, KEY_SECOND);
		wr(SEL_CONTROL, 8'h06);
		settle();
	endtask : put_word

	task automatic serial(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge core_clk);
		serial_wr_req <= 1'b1;
		serial_wr_addr <= a;
		serial_wr_data <= d;
		@(posedge core_clk);
		serial_wr_req <= 1'b0;
		repeat (3) @(posedge core_clk);
		#1;
	endtask : serial

	task automatic end_sim;
		$display("Comparisons %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_sim

	initial
	begin
		repeat (20000) @(posedge core_clk);
		failures++;
		end_sim();
	end

	initial
	begin
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		#1;
		chk(16'(reg_rd_data), 16'h0000);
		chk(16'(power_up_busy), 16'h0001);
		rd(SEL_CONTROL);
		chk(16'(v), 16'h0000);
		serial(10'h010, 14'h0123);
		chk(16'(refused_n), 16'h0001);
		wr(SEL_CONTROL, 8'h04);
		put_word(10'h003, 14'h0abc);
		chk(16'(erase_n + wq_a.size()), 16'h0000);
		for (int n = 0; n < 100 && power_up_busy !== 1'b0; n++) @(posedge core_clk);
		#1;
		chk(16'(power_up_busy), 16'h0000);
		foreach (rows[i])
		begin
			wr(rows[i].sel, rows[i].wd);
			rd(rows[i].sel);
			chk(16'(v), 16'(rows[i].exp));
		end
		for (int k = 0; k < 3; k++)
		begin
			wr(SEL_ADDR_LOW, 8'h03);
			wr(SEL_CONTROL, (k == 2) ? 8'h00 : 8'h04);
			wr(SEL_UNLOCK_KEY, (k == 0) ? KEY_SECOND : KEY_FIRST);
			if (k == 1) wr(SEL_ADDR_LOW, 8'h03);
			wr(SEL_UNLOCK_KEY, (k == 0) ? KEY_FIRST : KEY_SECOND);
			wr(SEL_CONTROL, 8'h06);
			settle();
			rd(SEL_CONTROL);
			chk(16'(v[CTRL_WR]), 16'h0000);
			chk(16'(erase_n + wq_a.size()), 16'h0000);
		end
		@(posedge core_clk) write_protect <= 1'b1;
		wr(SEL_CONTROL, 8'h04);
		clear_log();
		for (int i = 0; i < 3; i++) put_word(10'h104 + 10'(i), 14'h1a30 + 14'(i));
		chk(16'(stall_n), 16'h0000);
		chk(16'(wq_a.size() + erase_n), 16'h0000);
		put_word(10'h107, 14'h1a33);
		chk(16'(erase_n), 16'h0001);
		chk(16'(erase_addr), 16'h0100);
		chk(16'(stall_n >= ERASE_SIM), 16'h0001);
		chk(16'(cpu_stall), 16'h0000);
		chk(16'(wq_a.size()), 16'h0004);
		for (int i = 0; i < 4 && i < wq_a.size(); i++)
		begin
			chk(16'(wq_a[i]), 16'h0104 + 16'(i));
			chk(16'(wq_d[i]), 16'h1a30 + 16'(i));
		end
		rd(SEL_CONTROL);
		chk(16'(v[CTRL_WR]), 16'h0000);
		clear_log();
		for (int i = 0; i < 4; i++) put_word(10'h108 + 10'(i), 14'h0200 + 14'(i));
		chk(16'(erase_addr), 16'h0100);
		chk(16'(wq_a.size()), 16'h0004);
		chk(16'(wq_a[3]), 16'h010b);
		chk(16'(wq_d[3]), 16'h0203);
		@(posedge core_clk) segment_protect <= 4'h4;
		clear_log();
		put_word(10'h203, 14'h0555);
		chk(16'(erase_n + wq_a.size() + stall_n), 16'h0000);
		wr(SEL_ADDR_LOW, 8'hc3);
		wr(SEL_ADDR_HIGH, 8'h00);
		wr(SEL_CONTROL, 8'h05);
		settle();
		e = {4'h2, 10'h0c3};
		chk(16'(rd_addr), 16'h00c3);
		rd(SEL_DATA_LOW);
		chk(16'(v), 16'(e[7:0]));
		rd(SEL_DATA_HIGH);
		chk(16'(v), 16'({2'h0, e[13:8]}));
		@(posedge core_clk) segment_protect <= 4'h1;
		clear_log();
		serial(10'h010, 14'h0111);
		chk(16'(refused_n), 16'h0001);
		chk(16'(wq_a.size()), 16'h0000);
		serial(10'h310, 14'h2bcd);
		chk(16'(wq_a.size()), 16'h0001);
		chk(16'(wq_d[0]), 16'h2bcd);
		@(posedge core_clk) write_protect <= 1'b0;
		serial(10'h010, 14'h0222);
		chk(16'(wq_a.size()), 16'h0002);
		for (int i = 0; i < 4; i++)
		begin
			@(posedge core_clk);
			code_protect <= i[1];
			test_mode_req <= i[0];
			@(posedge core_clk);
			#1;
			chk(16'(test_mode_grant), 16'(i[0] & ~i[1]));
		end
		@(posedge core_clk) rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		rd(SEL_CONTROL);
		chk(16'(v), 16'h0000);
		end_sim();
	end
endmodule : tb
